// >>> core/rate_ctl.sv
// clock source choice and modulator / output word rate generation
// assumes clk runs faster than the system clock; sys_tick marks each 4.096 MHz
// system clock period, coming from whichever source is selected
`timescale 1ns/1ps
`include "rate_ctl_cfg.svh"

// Overview of operation
// [RQ1] grounded clock pin at reset selects internal oscillator
// [RQ2] any external clock disables oscillator, uses it
// [RQ3] external choice held until reset or power cycle
// [RQ4] modulator clock 32 to 512 kHz by rate
// [RQ5] divide ratio 128, 32, 16 or 8 by rate
// [RQ6] modulator bit stream clocked at modulator rate
// [RQ7] filter word rate follows chosen rate setting
// [RQ8] first word after a change is settled
// [RQ9] all rates scale with actual system clock
// [RQ10] 5 sps gives 5.018, 2000 gives 2000
// [RQ11] host picks 20 sps or less for mains rejection
// [RQ12] divide ratio chosen from rate select input
module rate_ctl
  import rate_ctl_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     clk_pin,
  input  wire logic                     int_clk_tick,
  input  wire logic                     ext_clk_tick,
  input  wire logic [`RATE_SEL_W-1:0]   rate_sel,
  input  wire logic                     mod_bit_in,
  output logic                          osc_enable,
  output logic                          use_ext_clk,
  output logic                          mod_clk_en,
  output logic                          mod_bit_out,
  output logic                          word_ready,
  output logic                          word_settled,
  output logic [7:0]                    div_ratio
);

  clk_src_t src_q;
  clk_src_t src_d;

  logic       pin_level;
  logic       pin_changed;
  logic [3:0] edge_cnt_q;
  logic [3:0] edge_cnt_d;
  logic       ext_seen;

  logic                   osc_en_q;
  logic                   use_ext_q;
  logic                   mod_en_q;
  logic                   mod_bit_q;
  logic                   word_q;
  logic                   settled_q;
  logic [7:0]             ratio_q;
  logic [`RATE_SEL_W-1:0] rate_q;

  logic        sys_tick;
  logic        mod_tick;
  logic        rate_change;
  logic [7:0]  ratio_sel;
  logic [15:0] words_per;
  logic [15:0] word_cnt_q;
  logic [15:0] word_cnt_d;
  logic        word_last;
  rate_out_t   rate_now;

  pin_sync u_pin (
    .clk     (clk),
    .resetn  (resetn),
    .pin     (clk_pin),
    .level   (pin_level),
    .changed (pin_changed)
  );

  // a few settled pin toggles mean a real clock, not a glitch
  assign edge_cnt_d = (src_q == SRC_EXT) ? edge_cnt_q :
                      (pin_changed && edge_cnt_q != `EXT_EDGE_COUNT) ?
                      edge_cnt_q + 4'h1 : edge_cnt_q;
  assign ext_seen   = (edge_cnt_q == `EXT_EDGE_COUNT);

  // boot state reads pin_level once after reset release, while it still holds its reset low
  always_comb begin
    src_d = src_q;
    unique case (src_q)
      SRC_BOOT: src_d = pin_level ? SRC_EXT : SRC_INT; // RQ1
      SRC_INT:  if (ext_seen) src_d = SRC_EXT;         // RQ2
      SRC_EXT:  src_d = SRC_EXT;                       // RQ3
      default:  src_d = SRC_INT;
    endcase
  end

  // external clock ticks are taken only once selected
  assign sys_tick = (src_q == SRC_EXT) ? ext_clk_tick : // RQ9
                    (src_q == SRC_INT) ? int_clk_tick : 1'b0;

  assign ratio_sel =
    (rate_sel <= `RATE_CODE_20)   ? `DIV_RATIO_SLOW : // RQ5
    (rate_sel <= `RATE_CODE_160)  ? `DIV_RATIO_MID  :
    (rate_sel <= `RATE_CODE_1000) ? `DIV_RATIO_FAST :
                                    `DIV_RATIO_TOP; // RQ12

  // modulator clocks per output word at each setting
  // indexed by the live code so a change reloads the new word length
  assign words_per =
    (rate_sel == `RATE_CODE_5)    ? `MOD_PER_WORD_5    : // RQ10
    (rate_sel == `RATE_CODE_10)   ? `MOD_PER_WORD_10   :
    (rate_sel == `RATE_CODE_20)   ? `MOD_PER_WORD_20   :
    (rate_sel == `RATE_CODE_40)   ? `MOD_PER_WORD_40   :
    (rate_sel == `RATE_CODE_80)   ? `MOD_PER_WORD_80   :
    (rate_sel == `RATE_CODE_160)  ? `MOD_PER_WORD_160  :
    (rate_sel == `RATE_CODE_320)  ? `MOD_PER_WORD_320  :
    (rate_sel == `RATE_CODE_640)  ? `MOD_PER_WORD_640  :
    (rate_sel == `RATE_CODE_1000) ? `MOD_PER_WORD_1000 :
                                    `MOD_PER_WORD_2000; // RQ7

  assign rate_change = (rate_sel != rate_q);

  tick_div #(.W(8)) u_mod (
    .clk     (clk),
    .resetn  (resetn),
    .en      (sys_tick),
    .restart (rate_change),
    .ratio   (ratio_sel),
    .tick    (mod_tick)
  ); // RQ4

  assign word_last  = (word_cnt_q == 16'h0001);
  // a rate change restarts the word count, so no partial word leaves
  assign word_cnt_d = rate_change ? words_per :
                      (mod_tick ? (word_last ? words_per
                                             : word_cnt_q - 16'h0001)
                                : word_cnt_q); // RQ8

  assign rate_now.mod_tick  = mod_tick;
  assign rate_now.word_tick = mod_tick && word_last && !rate_change;
  assign rate_now.div_ratio = ratio_sel;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_q      <= SRC_BOOT;
      edge_cnt_q <= 4'h0;
      rate_q     <= `RATE_CODE_20;
      word_cnt_q <= `MOD_PER_WORD_20;
    end else begin
      src_q      <= src_d;
      edge_cnt_q <= edge_cnt_d;
      rate_q     <= rate_sel;
      word_cnt_q <= word_cnt_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_en_q  <= 1'b1;
      use_ext_q <= 1'b0;
      mod_en_q  <= 1'b0;
      mod_bit_q <= 1'b0;
      word_q    <= 1'b0;
      settled_q <= 1'b0;
      ratio_q   <= `DIV_RATIO_SLOW;
    end else begin
      osc_en_q  <= (src_d != SRC_EXT); // RQ2
      use_ext_q <= (src_d == SRC_EXT); // RQ3
      mod_en_q  <= rate_now.mod_tick;
      if (rate_now.mod_tick)
        mod_bit_q <= mod_bit_in; // RQ6
      word_q    <= rate_now.word_tick;
      // every word is full-length since the last change
      settled_q <= rate_now.word_tick; // RQ8
      ratio_q   <= rate_now.div_ratio;
    end
  end

  assign osc_enable   = osc_en_q;
  assign use_ext_clk  = use_ext_q;
  assign mod_clk_en   = mod_en_q;
  assign mod_bit_out  = mod_bit_q;
  assign word_ready   = word_q;
  assign word_settled = settled_q;
  assign div_ratio    = ratio_q;
endmodule

// >>> shared/rate_ctl_cfg.svh
// timing counts and encodings for the converter clock and rate block
// assumes a 4.096 MHz system clock tick supplied to the block by the selected source
`ifndef RATE_CTL_CFG_SVH
`define RATE_CTL_CFG_SVH

`define CLK_PERIOD_NS        50
`define EXT_EDGE_COUNT       4'h4
`define DIV_RATIO_SLOW       8'h80
`define DIV_RATIO_MID        8'h20
`define DIV_RATIO_FAST       8'h10
`define DIV_RATIO_TOP        8'h08
`define RATE_SEL_W           4
`define RATE_CODE_5          4'h0
`define RATE_CODE_10         4'h1
`define RATE_CODE_20         4'h2
`define RATE_CODE_40         4'h3
`define RATE_CODE_80         4'h4
`define RATE_CODE_160        4'h5
`define RATE_CODE_320        4'h6
`define RATE_CODE_640        4'h7
`define RATE_CODE_1000       4'h8
`define RATE_CODE_2000       4'h9
// modulator clocks per word, set by the actual word rates, not nominal
`define MOD_PER_WORD_5       16'h18e9
`define MOD_PER_WORD_10      16'h0c74
`define MOD_PER_WORD_20      16'h063a
`define MOD_PER_WORD_40      16'h0c74
`define MOD_PER_WORD_80      16'h063a
`define MOD_PER_WORD_160     16'h031d
`define MOD_PER_WORD_320     16'h031c
`define MOD_PER_WORD_640     16'h018e
`define MOD_PER_WORD_1000    16'h0100
`define MOD_PER_WORD_2000    16'h0100

`endif

// >>> shared/rate_ctl_pkg.sv
// types for the converter clock and rate block
package rate_ctl_pkg;

  typedef enum logic [2:0] {
    SRC_BOOT = 3'b001,
    SRC_INT  = 3'b010,
    SRC_EXT  = 3'b100
  } clk_src_t;

  typedef struct packed {
    logic        mod_tick;
    logic        word_tick;
    logic [7:0]  div_ratio;
  } rate_out_t;

endpackage

// >>> core/pin_sync.sv
// three-stage synchroniser for one pin input
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      changed
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        lvl_q <= s3_q;
    end
  end

  // change counts only once stages two and three agree
  assign changed = (s2_q == s3_q) && (s3_q != lvl_q);
  assign level   = lvl_q;
endmodule

// >>> core/tick_div.sv
// loadable down-counter emitting a one-cycle tick per period
// assumes ratio is at least 1 and stable between loads
`timescale 1ns/1ps
module tick_div #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         en,
  input  wire logic         restart,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         last;

  assign last  = (cnt_q == {{(W-1){1'b0}}, 1'b1});
  assign tick  = en && last && !restart;
  assign cnt_d = restart ? ratio :
                 (en ? (last ? ratio : cnt_q - {{(W-1){1'b0}}, 1'b1})
                     : cnt_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      cnt_q <= {{(W-1){1'b0}}, 1'b1};
    else
      cnt_q <= cnt_d;
  end
endmodule

// >>> testbench/rate_ctl_checker.sv
// port assertions for the clock source and rate block
// assumes one clk domain with async active-low resetn
`timescale 1ns/1ps
`include "rate_ctl_cfg.svh"
module rate_ctl_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       clk_pin,
  input wire logic       int_clk_tick,
  input wire logic       ext_clk_tick,
  input wire logic [3:0] rate_sel,
  input wire logic       mod_bit_in,
  input wire logic       osc_enable,
  input wire logic       use_ext_clk,
  input wire logic       mod_clk_en,
  input wire logic       mod_bit_out,
  input wire logic       word_ready,
  input wire logic       word_settled,
  input wire logic [7:0] div_ratio
);
  logic [7:0] cnt_q;
  logic [3:0] rs_q;
  logic       ue_q;
  logic       ok_q;
  // a period is only judged once a whole one follows any change
  wire chg = (rate_sel != rs_q) || (use_ext_clk != ue_q);
  wire sel_tick = use_ext_clk ? ext_clk_tick : int_clk_tick;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      rs_q <= 4'h0;
      ue_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      rs_q <= rate_sel;
      ue_q <= use_ext_clk;
      ok_q <= chg ? 1'b0 : (mod_clk_en | ok_q);
      cnt_q <= (mod_clk_en | chg) ? 8'(sel_tick) : cnt_q + 8'(sel_tick);
    end
  end
  function automatic logic [7:0] ratio_of(input logic [3:0] c);
    return c < 4'h3 ? `DIV_RATIO_SLOW : c < 4'h6 ? `DIV_RATIO_MID :
           c < 4'h9 ? `DIV_RATIO_FAST : `DIV_RATIO_TOP;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ratio_by_rate: assert property ($past(resetn) && $stable(rate_sel)
    |-> div_ratio == ratio_of(rate_sel)) else $error("ratio off rate");
  a_ratio_legal: assert property (div_ratio inside {8'h08, 8'h10,
    8'h20, 8'h80}) else $error("ratio not legal");
  a_mod_period: assert property (mod_clk_en && ok_q
    |-> cnt_q == div_ratio) else $error("modulator period wrong");
  a_int_when_off: assert property (!use_ext_clk |-> osc_enable)
    else $error("oscillator off on internal");
  a_ext_osc_off: assert property (use_ext_clk |=> !osc_enable)
    else $error("oscillator on with external");
  a_ext_sticky: assert property (use_ext_clk |=> use_ext_clk)
    else $error("external choice dropped");
  a_mod_pulse: assert property (mod_clk_en |=> !mod_clk_en)
    else $error("modulator pulse too long");
  a_bit_at_tick: assert property ($changed(mod_bit_out)
    |-> mod_clk_en || $past(mod_clk_en)) else $error("bit off tick");
  a_word_settled: assert property (word_ready |-> word_settled)
    else $error("word not settled");
  a_settled_only: assert property (word_settled |-> word_ready)
    else $error("settled without word");
  c_period: cover property (mod_clk_en && ok_q);
  c_ext: cover property ($rose(use_ext_clk));
  c_word: cover property (word_ready);
endmodule
bind rate_ctl rate_ctl_checker u_chk (.clk(clk), .resetn(resetn),
  .clk_pin(clk_pin), .int_clk_tick(int_clk_tick),
  .ext_clk_tick(ext_clk_tick), .rate_sel(rate_sel),
  .mod_bit_in(mod_bit_in), .osc_enable(osc_enable),
  .use_ext_clk(use_ext_clk), .mod_clk_en(mod_clk_en),
  .mod_bit_out(mod_bit_out), .word_ready(word_ready),
  .word_settled(word_settled), .div_ratio(div_ratio));

// >>> testbench/ext_clk_src.sv
// external system clock source: pin toggles and one tick per pin toggle
// assumes clk runs free; en low holds the pin at digital ground
`timescale 1ns/1ps
module ext_clk_src (
  input  wire logic clk,
  input  wire logic en,
  output logic      clk_pin,
  output logic      ext_tick
);
  logic [1:0] ph = 2'h0;
  initial begin
    clk_pin = 1'b0;
    ext_tick = 1'b0;
  end
  // faster than the oscillator, so scaling shows in cycle counts
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    ext_tick <= en && ph == 2'h3;
    clk_pin <= en ? clk_pin ^ (ph == 2'h3) : 1'b0;
  end
endmodule

// >>> testbench/adc_clock_and_rate_control_bench.sv
// bench for the clock source and rate block, with an integer model
// assumes ext_clk_src stands on the clock pin
`timescale 1ns/1ps
`include "rate_ctl_cfg.svh"
module adc_clock_and_rate_control_bench;
  logic       clk = 1'b0, resetn = 1'b0, int_clk_tick = 1'b0;
  logic       mod_bit_in = 1'b0, src_en = 1'b0, last_bit = 1'b0;
  logic [3:0] rate_sel = `RATE_CODE_20;
  logic       clk_pin, ext_clk_tick, osc_enable, use_ext_clk, mod_clk_en;
  logic       mod_bit_out, word_ready, word_settled;
  logic [7:0] div_ratio;
  int         n_fail = 0, n_compared = 0, seed = 37, cyc = 0, tcnt = 0;
  int         mcnt = 0, gap = 0, words = 0, n_mod = 0, n_word = 0;
  always #25 clk = ~clk;
  ext_clk_src u_src (.clk(clk), .en(src_en), .clk_pin(clk_pin),
    .ext_tick(ext_clk_tick));
  rate_ctl u_dut (.clk(clk), .resetn(resetn), .clk_pin(clk_pin),
    .int_clk_tick(int_clk_tick), .ext_clk_tick(ext_clk_tick),
    .rate_sel(rate_sel), .mod_bit_in(mod_bit_in),
    .osc_enable(osc_enable), .use_ext_clk(use_ext_clk),
    .mod_clk_en(mod_clk_en), .mod_bit_out(mod_bit_out),
    .word_ready(word_ready), .word_settled(word_settled),
    .div_ratio(div_ratio));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic int exp_ratio(input logic [3:0] c);
    return c < 3 ? 128 : c < 6 ? 32 : c < 9 ? 16 : 8;
  endfunction
  // model: system ticks per modulator pulse, pulses per word
  always @(posedge clk) begin
    cyc <= cyc + 1;
    int_clk_tick <= (cyc % 5 == 4);
    mod_bit_in <= 1'($random(seed));
    if (mod_clk_en === 1'b1) begin
      gap = tcnt;
      tcnt = 0;
      n_mod++;
      mcnt++;
      check(32'(mod_bit_out), 32'(last_bit));
    end
    if ((use_ext_clk ? ext_clk_tick : int_clk_tick) === 1'b1) tcnt++;
    if (word_ready === 1'b1) begin
      check(32'(word_settled), 32'h1);
      words = mcnt;
      mcnt = 0;
      n_word++;
    end
    // bit the design sampled at this edge, shown with the next pulse
    last_bit = mod_bit_in;
    if (cyc == 100000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic measure(input logic [3:0] code, input int want_words);
    int n0;
    rate_sel <= code;
    n0 = n_mod;
    while (n_mod < n0 + 3) @(posedge clk);
    check(32'(div_ratio), 32'(exp_ratio(code)));
    check(gap, exp_ratio(code));
    if (want_words > 0) begin
      n0 = n_word;
      while (n_word < n0 + 2) @(posedge clk);
      check(words, want_words);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'({osc_enable, use_ext_clk}), 32'h2);
    for (int c = 0; c < 11; c++) measure(4'(c), 0);
    measure(`RATE_CODE_2000, 256);
    src_en <= 1'b1;
    repeat (60) @(posedge clk);
    check(32'({osc_enable, use_ext_clk}), 32'h1);
    measure(`RATE_CODE_2000, 256);
    src_en <= 1'b0;
    repeat (60) @(posedge clk);
    check(32'(use_ext_clk), 32'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'({osc_enable, use_ext_clk}), 32'h2);
    conclude();
  end
endmodule
